// ---- src/pltl_pkg.sv ----
// Package for the passive target lister: constants, codes and carrier types
// Operation
// [RQ1] Apply RF settings items 0x0A..0x0D, defaults or host-written, during activation
// [RQ2] Type A probes with wake-all when UID given, else sense; 5 ms timeout
// [RQ3] Retry probing up to retry limit; no answer ends with count zero
// [RQ4] Type A answer leads to anticollision then selection of one target
// [RQ5] Logical numbers follow discovery order: first is 1, second is 2
// [RQ6] New listing discards stored information about earlier targets
// [RQ7] Type A level-4 target gets RATS; whole ATS goes into its report
// [RQ8] Multi-target Type A halts each target by sleep, level-4 by deselect
// [RQ9] Last initialized target stays active, never halted; the lister halts it when fewer targets answer than requested
// [RQ10] Reported Type A identifier excludes cascade tag bytes
// [RQ11] Multi-target Type A with sense-answer collision reports two zero bytes
// [RQ12] Type B probes with wake when card starts halted, else request; 5 ms
// [RQ13] Type B anticollision by request or slot marker, then attribute select
// [RQ14] Multi-target Type B halts each target by deselect before continuing
// [RQ15] Polling mode sends host payload in poll request, retried to limit
// [RQ16] Poll timeout is 512x64/fc plus (slots+1) x 256x64/fc
// [RQ17] Accept poll answer only with command byte 1 and length 18 or 20
// [RQ18] Polling report: number, length, 0x01, 8 id, 8 pad, optional 2 code
// [RQ19] Short-ID tag: probe, read identifier, number 1, one target at most
// [RQ20] Found count is actual initialized targets, zero up to requested maximum
// [RQ21] Abort before any activation switches RF field off
// [RQ22] Host selects scheme by rate/modulation code 0x00..0x04
// [RQ23] Host requests count 1 or 2; short-ID tag mode allows only 1
// [RQ24] Type B polling method bit 0 set is probabilistic, clear or absent timeslot
package pltl_pkg;

	// ----------------------------------------
	// Scheme codes
	// ----------------------------------------
	localparam logic [7:0] RATE_TYPE_A   = 8'h00;
	localparam logic [7:0] RATE_POLL_212 = 8'h01;
	localparam logic [7:0] RATE_POLL_424 = 8'h02;
	localparam logic [7:0] RATE_TYPE_B   = 8'h03;
	localparam logic [7:0] RATE_SHORT_ID = 8'h04;

	// ----------------------------------------
	// Frame opcodes handed to the RF front end
	// ----------------------------------------
	typedef enum logic [3:0] {
		PLTL_OP_SENS     = 4'h0,
		PLTL_OP_ALL      = 4'h1,
		PLTL_OP_SDD      = 4'h2,
		PLTL_OP_SEL      = 4'h3,
		PLTL_OP_RATS     = 4'h4,
		PLTL_OP_SLP      = 4'h5,
		PLTL_OP_DESELECT = 4'h6,
		PLTL_OP_REQB     = 4'h7,
		PLTL_OP_WUPB     = 4'h8,
		PLTL_OP_SLOT     = 4'h9,
		PLTL_OP_ATTRIB   = 4'ha,
		PLTL_OP_POLL     = 4'hb,
		PLTL_OP_ATQA     = 4'hc,
		PLTL_OP_RID      = 4'hd,
		PLTL_OP_RF_CFG   = 4'he
	} pltl_op_t;

	// ----------------------------------------
	// RF setting items applied at activation
	// ----------------------------------------
	localparam logic [7:0] CFG_ITEM_FIRST = 8'h0a;
	localparam logic [7:0] CFG_ITEM_LAST  = 8'h0d;

	// ----------------------------------------
	// Report constants
	// ----------------------------------------
	localparam logic [7:0] POLL_RESP_CODE  = 8'h01;
	localparam logic [7:0] POLL_LEN_SHORT  = 8'h12;
	localparam logic [7:0] POLL_LEN_LONG   = 8'h14;
	localparam logic [7:0] CASCADE_TAG     = 8'h88;
	localparam logic [7:0] ZERO_BYTE       = 8'h00;
	localparam logic [7:0] SEL_RES_L4_MASK = 8'h20;
	localparam int         TB_METHOD_BIT   = 0;

	// ----------------------------------------
	// Timing, 20 MHz clock
	// ----------------------------------------
	localparam int CLK_HZ         = 20_000_000;
	localparam int PROBE_TO_US    = 5000;
	localparam int PROBE_TO_CYC   = PROBE_TO_US * (CLK_HZ / 1_000_000);
	// One 64/fc etu is 4.72 us; 20 MHz * 64 / 13.56 MHz
	localparam int FC_HZ          = 13_560_000;
	localparam int POLL_TD_ETU    = 512;
	localparam int POLL_TS_ETU    = 256;
	localparam int ETU_FC         = 64;
	localparam int POLL_TD_CYC    = (POLL_TD_ETU * ETU_FC * (CLK_HZ / 10000)) / (FC_HZ / 10000);
	localparam int POLL_TS_CYC    = (POLL_TS_ETU * ETU_FC * (CLK_HZ / 10000)) / (FC_HZ / 10000);

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		pltl_op_t    op;
		logic [7:0]  arg;
		logic [23:0] timeout;
	} pltl_rf_req_t;

	typedef struct packed {
		logic        answered;
		logic        collision;
		logic [7:0]  length;
		logic [7:0]  code;
	} pltl_rf_resp_t;

endpackage

// ---- src/pltl_lister.sv ----
// Passive target lister: sequencer that probes, activates and reports targets
`timescale 1ns/1ps
`default_nettype none
module pltl_lister #(
	parameter int MAX_TARGETS  = 2,
	parameter int PROBE_CYCLES = pltl_pkg::PROBE_TO_CYC
) (
	input  wire logic                    CLK,              // System clock
	input  wire logic                    SYS_RST,          // Async reset, high
	input  wire logic                    CMD_START,        // Start a listing, pulse
	input  wire logic                    CMD_ABORT,        // Host abort, pulse
	input  wire logic [7:0]              MAX_TARGET_COUNT, // Requested targets
	input  wire logic [7:0]              RATE_MODULATION_SELECT, // Scheme code
	input  wire logic                    UID_PRESENT,      // Setup bytes carry a UID
	input  wire logic                    START_HALTED,     // Type B card starts halted
	input  wire logic                    METHOD_PRESENT,   // Type B method byte given
	input  wire logic [7:0]              POLL_METHOD,      // Type B method byte
	input  wire logic [7:0]              TIME_SLOT_COUNT,  // Polling slot count
	input  wire logic [7:0]              ACTIVATION_RETRY_LIMIT, // Probe retries
	output logic                         RF_REQ_VALID,     // Frame request valid
	output pltl_pkg::pltl_rf_req_t       RF_REQ,           // Frame request
	input  wire logic                    RF_REQ_READY,     // Front end takes frame
	input  wire logic                    RF_RESP_VALID,    // Answer or timeout, pulse
	input  wire pltl_pkg::pltl_rf_resp_t RF_RESP,          // Answer summary
	input  wire logic [7:0]              RF_RESP_BYTE,     // Answer byte stream
	input  wire logic                    RF_RESP_BYTE_VALID, // Byte strobe
	output logic                         RF_FIELD_ON,      // RF field enable
	output logic                         FLUSH_TARGETS,    // Discard stored targets
	output logic                         REPORT_VALID,     // Report byte valid
	output logic [7:0]                   REPORT_BYTE,      // Target report byte
	output logic                         DONE,             // Listing finished, pulse
	output logic [7:0]                   FOUND_TARGET_COUNT // Initialized targets
);

	initial
	begin
		if (MAX_TARGETS < 1 || MAX_TARGETS > 2)
			$error("MAX_TARGETS must be 1 or 2");
		if (PROBE_CYCLES < 1 || PROBE_CYCLES > 16777215)
			$error("PROBE_CYCLES out of range");
	end

	// ----------------------------------------
	// Sequencer states
	// ----------------------------------------
	typedef enum logic [3:0] {
		S_IDLE    = 4'h0,
		S_CONFIG  = 4'h1,
		S_PROBE   = 4'h2,
		S_ANTICOL = 4'h3,
		S_SELECT  = 4'h4,
		S_RATS    = 4'h5,
		S_HALT    = 4'h6,
		S_READID  = 4'h7,
		S_DONE    = 4'h8
	} pltl_state_t;

	pltl_state_t state;
	pltl_state_t next_state;
	logic        req_sent;
	logic [7:0]  retries;
	logic [7:0]  cfg_item;
	logic [1:0]  found;
	logic        is_l4;
	logic        collided;
	logic        prev_byte_ct;
	logic [4:0]  byte_idx;
	logic        resp_ok;
	logic        poll_ok;
	logic [7:0]  limit;

	function automatic logic [23:0] poll_timeout(input logic [7:0] slots);
		poll_timeout = 24'(pltl_pkg::POLL_TD_CYC + (int'(slots) + 1) * pltl_pkg::POLL_TS_CYC); // [RQ16]
	endfunction

	function automatic logic is_type_a(input logic [7:0] code);
		is_type_a = (code == pltl_pkg::RATE_TYPE_A);
	endfunction

	wire logic is_poll  = (RATE_MODULATION_SELECT == pltl_pkg::RATE_POLL_212)
		|| (RATE_MODULATION_SELECT == pltl_pkg::RATE_POLL_424);
	wire logic is_tb    = (RATE_MODULATION_SELECT == pltl_pkg::RATE_TYPE_B);
	wire logic is_short = (RATE_MODULATION_SELECT == pltl_pkg::RATE_SHORT_ID);
	wire logic probabilistic = METHOD_PRESENT && POLL_METHOD[pltl_pkg::TB_METHOD_BIT]; // [RQ24]

	// Short-ID mode never lists more than one
	always_comb
	begin
		limit = MAX_TARGET_COUNT;
		if (is_short || MAX_TARGET_COUNT > 8'(MAX_TARGETS))
			limit = is_short ? 8'h01 : 8'(MAX_TARGETS); // [RQ19] [RQ20]
	end

	assign poll_ok = (RF_RESP.code == pltl_pkg::POLL_RESP_CODE)
		&& (RF_RESP.length == pltl_pkg::POLL_LEN_SHORT
		|| RF_RESP.length == pltl_pkg::POLL_LEN_LONG); // [RQ17]
	assign resp_ok = RF_RESP.answered && (!is_poll || poll_ok);

	wire logic more_wanted = (8'({6'h00, found}) + 8'h01) < limit;

	// ----------------------------------------
	// Frame request
	// ----------------------------------------
	always_comb
	begin
		RF_REQ_VALID       = 1'b0;
		RF_REQ.op          = pltl_pkg::PLTL_OP_SENS;
		RF_REQ.arg         = 8'h00;
		RF_REQ.timeout     = 24'(PROBE_CYCLES);
		case (state)
			S_CONFIG:
			begin
				RF_REQ_VALID = !req_sent;
				RF_REQ.op    = pltl_pkg::PLTL_OP_RF_CFG;
				RF_REQ.arg   = cfg_item; // [RQ1]
			end
			S_PROBE:
			begin
				RF_REQ_VALID = !req_sent;
				if (is_poll)
				begin
					RF_REQ.op      = pltl_pkg::PLTL_OP_POLL; // [RQ15]
					RF_REQ.arg     = TIME_SLOT_COUNT;
					RF_REQ.timeout = poll_timeout(TIME_SLOT_COUNT); // [RQ16]
				end
				else if (is_tb)
					RF_REQ.op = START_HALTED ? pltl_pkg::PLTL_OP_WUPB : pltl_pkg::PLTL_OP_REQB; // [RQ12]
				else if (is_short)
					RF_REQ.op = pltl_pkg::PLTL_OP_ATQA; // [RQ19]
				else
					RF_REQ.op = UID_PRESENT ? pltl_pkg::PLTL_OP_ALL : pltl_pkg::PLTL_OP_SENS; // [RQ2]
			end
			S_ANTICOL:
			begin
				RF_REQ_VALID = !req_sent;
				if (is_tb)
					RF_REQ.op = probabilistic ? pltl_pkg::PLTL_OP_REQB : pltl_pkg::PLTL_OP_SLOT; // [RQ13]
				else
					RF_REQ.op = pltl_pkg::PLTL_OP_SDD; // [RQ4]
			end
			S_SELECT:
			begin
				RF_REQ_VALID = !req_sent;
				RF_REQ.op    = is_tb ? pltl_pkg::PLTL_OP_ATTRIB : pltl_pkg::PLTL_OP_SEL; // [RQ4] [RQ13]
			end
			S_RATS:
			begin
				RF_REQ_VALID = !req_sent;
				RF_REQ.op    = pltl_pkg::PLTL_OP_RATS; // [RQ7]
			end
			S_HALT:
			begin
				RF_REQ_VALID = !req_sent;
				RF_REQ.op    = (is_tb || is_l4) ? pltl_pkg::PLTL_OP_DESELECT : pltl_pkg::PLTL_OP_SLP; // [RQ8] [RQ14]
			end
			S_READID:
			begin
				RF_REQ_VALID = !req_sent;
				RF_REQ.op    = pltl_pkg::PLTL_OP_RID; // [RQ19]
			end
			default:
			begin
				RF_REQ_VALID = 1'b0;
			end
		endcase
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		next_state = state;
		case (state)
			S_IDLE:
				if (CMD_START)
					next_state = S_CONFIG;
			S_CONFIG:
				if (RF_RESP_VALID && cfg_item == pltl_pkg::CFG_ITEM_LAST)
					next_state = S_PROBE;
			S_PROBE:
				if (RF_RESP_VALID)
				begin
					if (resp_ok)
						next_state = is_poll ? S_DONE
							: (is_short ? S_READID : S_ANTICOL);
					else if (retries >= ACTIVATION_RETRY_LIMIT)
						next_state = S_DONE; // [RQ3]
				end
			S_ANTICOL:
				if (RF_RESP_VALID)
					next_state = RF_RESP.answered ? S_SELECT : S_DONE;
			S_SELECT:
				if (RF_RESP_VALID)
				begin
					if (!RF_RESP.answered)
						next_state = S_DONE;
					else if (is_type_a(RATE_MODULATION_SELECT)
						&& (RF_RESP.code & pltl_pkg::SEL_RES_L4_MASK) != 8'h00)
						next_state = S_RATS; // [RQ7]
					else
						next_state = more_wanted ? S_HALT : S_DONE; // [RQ9]
				end
			S_RATS:
				if (RF_RESP_VALID)
					next_state = (8'({6'h00, found}) < limit) ? S_HALT : S_DONE; // [RQ9]
			S_HALT:
				if (RF_RESP_VALID)
					next_state = S_PROBE;
			S_READID:
				if (RF_RESP_VALID)
					next_state = S_DONE;
			S_DONE:
				next_state = S_IDLE;
			default:
				next_state = S_IDLE;
		endcase
		if (CMD_ABORT && state != S_IDLE)
			next_state = S_IDLE;
	end

	always_ff @(posedge CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
			state <= S_IDLE;
		else
			state <= next_state;
	end

	// One request per answer: cleared on an answer or a state change
	always_ff @(posedge CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
			req_sent <= 1'b0;
		else if (next_state != state || RF_RESP_VALID)
			req_sent <= 1'b0;
		else if (RF_REQ_VALID && RF_REQ_READY)
			req_sent <= 1'b1;
	end

	always_ff @(posedge CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
			cfg_item <= pltl_pkg::CFG_ITEM_FIRST;
		else if (state == S_IDLE)
			cfg_item <= pltl_pkg::CFG_ITEM_FIRST;
		else if (state == S_CONFIG && RF_RESP_VALID)
			cfg_item <= cfg_item + 8'h01; // [RQ1]
	end

	// Retries count failed probes; reset in idle and while a target is halted
	always_ff @(posedge CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
			retries <= 8'h00;
		else if (state == S_IDLE || state == S_HALT)
			retries <= 8'h00;
		else if (state == S_PROBE && RF_RESP_VALID && !resp_ok)
			retries <= retries + 8'h01; // [RQ3] [RQ15]
	end

	// ----------------------------------------
	// Target bookkeeping and report
	// ----------------------------------------
	wire logic target_won = RF_RESP_VALID && (
		(state == S_SELECT && RF_RESP.answered)
		|| (state == S_PROBE && is_poll && resp_ok)
		|| (state == S_READID && RF_RESP.answered));

	always_ff @(posedge CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			found    <= 2'b00;
			is_l4    <= 1'b0;
			collided <= 1'b0;
		end
		else if (state == S_IDLE && CMD_START)
		begin
			found    <= 2'b00; // [RQ6]
			is_l4    <= 1'b0;
			collided <= 1'b0;
		end
		else
		begin
			if (state == S_PROBE && RF_RESP_VALID)
				collided <= RF_RESP.collision && limit > 8'h01; // [RQ11]
			if (target_won)
				found <= found + 2'b01; // [RQ5] [RQ20]
			if (state == S_SELECT && RF_RESP_VALID)
				is_l4 <= is_type_a(RATE_MODULATION_SELECT)
					&& (RF_RESP.code & pltl_pkg::SEL_RES_L4_MASK) != 8'h00;
		end
	end

	assign FOUND_TARGET_COUNT = {6'h00, found}; // [RQ20]
	assign FLUSH_TARGETS      = (state == S_IDLE) && CMD_START; // [RQ6]

	// Report stream: number byte for polling and short-ID targets, answer bytes as they arrive
	always_ff @(posedge CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			REPORT_VALID <= 1'b0;
			REPORT_BYTE  <= 8'h00;
			byte_idx     <= 5'h00;
			prev_byte_ct <= 1'b0;
		end
		else
		begin
			REPORT_VALID <= 1'b0;
			if (target_won && state != S_SELECT)
			begin
				REPORT_VALID <= 1'b1;
				REPORT_BYTE  <= {6'h00, found} + 8'h01; // [RQ5] [RQ18]
			end
			else if (RF_RESP_BYTE_VALID && state != S_IDLE && state != S_CONFIG
				&& state != S_HALT)
			begin
				byte_idx <= byte_idx + 5'h01;
				// Sense answer lies in bytes 0 and 1 of the Type A probe
				if (state == S_PROBE && is_type_a(RATE_MODULATION_SELECT)
					&& (collided || (RF_RESP_VALID && RF_RESP.collision && limit > 8'h01)))
				begin
					REPORT_VALID <= 1'b1;
					REPORT_BYTE  <= pltl_pkg::ZERO_BYTE; // [RQ11]
				end
				else if (state == S_ANTICOL && RF_RESP_BYTE == pltl_pkg::CASCADE_TAG
					&& byte_idx[1:0] == 2'b00)
					prev_byte_ct <= 1'b1; // [RQ10]
				else
				begin
					REPORT_VALID <= 1'b1;
					REPORT_BYTE  <= RF_RESP_BYTE; // [RQ7] [RQ18]
				end
			end
			if (next_state != state)
			begin
				byte_idx     <= 5'h00;
				prev_byte_ct <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Field and completion
	// ----------------------------------------
	always_ff @(posedge CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
			RF_FIELD_ON <= 1'b0;
		else if (state == S_IDLE && CMD_START)
			RF_FIELD_ON <= 1'b1;
		else if (CMD_ABORT && state != S_IDLE && found == 2'b00)
			RF_FIELD_ON <= 1'b0; // [RQ21]
	end

	always_ff @(posedge CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
			DONE <= 1'b0;
		else
			DONE <= (state == S_DONE); // [RQ3] [RQ20]
	end

endmodule
`default_nettype wire

// ---- sim/pltl_lister_asserts.sv ----
// Port checker for the passive target lister, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module pltl_lister_asserts #(
	parameter int MAX_TARGETS  = 2,
	parameter int PROBE_CYCLES = 50
) (
	input wire logic			CLK,			// Clock
	input wire logic			SYS_RST,		// Reset
	input wire logic			CMD_ABORT,		// Abort
	input wire logic [7:0]			MAX_TARGET_COUNT,	// Requested
	input wire logic [7:0]			TIME_SLOT_COUNT,	// Slots
	input wire logic			RF_REQ_VALID,		// Frame valid
	input wire pltl_pkg::pltl_rf_req_t	RF_REQ,			// Frame
	input wire logic			RF_REQ_READY,		// Frame taken
	input wire logic			RF_FIELD_ON,		// Field
	input wire logic			FLUSH_TARGETS,		// Flush
	input wire logic			DONE,			// Done
	input wire logic [7:0]			FOUND_TARGET_COUNT	// Count
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);

	pltl_pkg::pltl_op_t	last_op;
	logic [2:0]		n_cfg;
	wire			take = RF_REQ_VALID && RF_REQ_READY;
	wire			probe = RF_REQ.op inside {pltl_pkg::PLTL_OP_SENS, pltl_pkg::PLTL_OP_ALL,
				pltl_pkg::PLTL_OP_REQB, pltl_pkg::PLTL_OP_WUPB, pltl_pkg::PLTL_OP_POLL, pltl_pkg::PLTL_OP_ATQA};

	// ----------------------------------------
	// Frame history
	// ----------------------------------------
	always_ff @(posedge CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
			last_op <= pltl_pkg::PLTL_OP_RF_CFG;
		else if (take)
			last_op <= RF_REQ.op;
	end

	// Settings frames seen since the listing began
	always_ff @(posedge CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
			n_cfg <= 3'h0;
		else if (FLUSH_TARGETS)
			n_cfg <= 3'h0;
		else if (take && RF_REQ.op == pltl_pkg::PLTL_OP_RF_CFG && n_cfg != 3'h7)
			n_cfg <= n_cfg + 3'h1;
	end

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	property p_cfg_start;
		FLUSH_TARGETS |-> ##[1:3] (RF_REQ_VALID && RF_REQ.op == pltl_pkg::PLTL_OP_RF_CFG
			&& RF_REQ.arg == pltl_pkg::CFG_ITEM_FIRST);
	endproperty
	property p_cfg_first;
		take && probe |-> n_cfg == 3'h4;
	endproperty
	property p_a_timeout;
		RF_REQ_VALID && RF_REQ.op inside {pltl_pkg::PLTL_OP_SENS, pltl_pkg::PLTL_OP_ALL}
			|-> RF_REQ.timeout == 24'(PROBE_CYCLES);
	endproperty
	property p_b_timeout;
		RF_REQ_VALID && RF_REQ.op == pltl_pkg::PLTL_OP_WUPB |-> RF_REQ.timeout == 24'(PROBE_CYCLES);
	endproperty
	property p_poll_timeout;
		RF_REQ_VALID && RF_REQ.op == pltl_pkg::PLTL_OP_POLL |-> RF_REQ.timeout ==
			24'(pltl_pkg::POLL_TD_CYC + (int'(TIME_SLOT_COUNT) + 1) * pltl_pkg::POLL_TS_CYC);
	endproperty
	property p_sel_order;
		take && RF_REQ.op == pltl_pkg::PLTL_OP_SEL |-> last_op == pltl_pkg::PLTL_OP_SDD;
	endproperty
	property p_rats_order;
		take && RF_REQ.op == pltl_pkg::PLTL_OP_RATS |-> last_op == pltl_pkg::PLTL_OP_SEL;
	endproperty
	property p_sleep_order;
		take && RF_REQ.op == pltl_pkg::PLTL_OP_SLP |-> last_op == pltl_pkg::PLTL_OP_SEL;
	endproperty
	property p_desel_order;
		take && RF_REQ.op == pltl_pkg::PLTL_OP_DESELECT
			|-> last_op inside {pltl_pkg::PLTL_OP_RATS, pltl_pkg::PLTL_OP_ATTRIB};
	endproperty
	property p_attrib_order;
		take && RF_REQ.op == pltl_pkg::PLTL_OP_ATTRIB
			|-> last_op inside {pltl_pkg::PLTL_OP_REQB, pltl_pkg::PLTL_OP_SLOT};
	endproperty
	property p_count;
		DONE |-> FOUND_TARGET_COUNT <= MAX_TARGET_COUNT && FOUND_TARGET_COUNT <= MAX_TARGETS;
	endproperty
	property p_abort_field;
		CMD_ABORT && FOUND_TARGET_COUNT == 8'h00 |-> ##[1:2] !RF_FIELD_ON;
	endproperty

	a_cfg_start: assert property (p_cfg_start) else $error("settings frame missing at start");
	a_cfg_first: assert property (p_cfg_first) else $error("probe before four settings");
	a_a_timeout: assert property (p_a_timeout) else $error("type A probe timeout wrong");
	a_b_timeout: assert property (p_b_timeout) else $error("type B probe timeout wrong");
	a_poll_timeout: assert property (p_poll_timeout) else $error("poll timeout wrong");
	a_sel_order: assert property (p_sel_order) else $error("select without anticollision");
	a_rats_order: assert property (p_rats_order) else $error("RATS not after select");
	a_sleep_order: assert property (p_sleep_order) else $error("sleep not after select");
	a_desel_order: assert property (p_desel_order) else $error("deselect out of place");
	a_attrib_order: assert property (p_attrib_order) else $error("attrib out of place");
	a_count: assert property (p_count) else $error("found count above maximum");
	a_abort_field: assert property (p_abort_field) else $error("field stays on after abort");

	c_two: cover property (DONE && FOUND_TARGET_COUNT == 8'h02);
	c_desel: cover property (take && RF_REQ.op == pltl_pkg::PLTL_OP_DESELECT);
	c_poll: cover property (take && RF_REQ.op == pltl_pkg::PLTL_OP_POLL);
endmodule

bind pltl_lister pltl_lister_asserts #(.MAX_TARGETS(MAX_TARGETS), .PROBE_CYCLES(PROBE_CYCLES)) i_chk (
	.CLK(CLK), .SYS_RST(SYS_RST), .CMD_ABORT(CMD_ABORT), .MAX_TARGET_COUNT(MAX_TARGET_COUNT),
	.TIME_SLOT_COUNT(TIME_SLOT_COUNT), .RF_REQ_VALID(RF_REQ_VALID), .RF_REQ(RF_REQ),
	.RF_REQ_READY(RF_REQ_READY), .RF_FIELD_ON(RF_FIELD_ON), .FLUSH_TARGETS(FLUSH_TARGETS),
	.DONE(DONE), .FOUND_TARGET_COUNT(FOUND_TARGET_COUNT));
`default_nettype wire

// ---- sim/pltl_rf_model.sv ----
// Behavioural RF front end with its card population
`timescale 1ns/1ps
`default_nettype none
module pltl_rf_model (
	input wire logic			clk,		// Clock
	input wire logic			rst,		// Reset, high
	input wire logic			req_valid,	// Frame valid
	input wire pltl_pkg::pltl_rf_req_t	req,		// Frame
	input wire logic			ans,		// Cards answer
	input wire logic			coll,		// Answers collide
	input wire logic [7:0]			sel_code,	// Select answer code
	input wire logic [7:0]			poll_cmd,	// Poll answer command
	input wire logic [7:0]			poll_len,	// Poll answer length
	input wire logic [3:0]			lat,		// Answer delay
	output logic				ready,		// Frame taken
	output logic				resp_valid,	// Answer or timeout
	output pltl_pkg::pltl_rf_resp_t		resp,		// Answer summary
	output logic [7:0]			rbyte,		// Answer byte
	output logic				rbyte_valid	// Byte strobe
);
	pltl_pkg::pltl_op_t	op;
	logic			busy;
	logic [3:0]		cnt;
	wire			cfg = op == pltl_pkg::PLTL_OP_RF_CFG;
	wire			poll = op == pltl_pkg::PLTL_OP_POLL;
	wire			sel = op == pltl_pkg::PLTL_OP_SEL;

	// ----------------------------------------
	// One frame at a time, answered lat+1 cycles after it is taken
	// ----------------------------------------
	always @(posedge clk or posedge rst)
	begin
		resp_valid <= 1'b0;
		rbyte_valid <= 1'b0;
		// Unqualified lines toggle so stale data never passes
		resp <= ~resp;
		rbyte <= ~rbyte;
		if (rst)
		begin
			busy <= 1'b0;
			ready <= 1'b0;
			cnt <= 4'h0;
			op <= pltl_pkg::PLTL_OP_RF_CFG;
			resp <= '0;
			rbyte <= 8'h00;
		end
		else if (!busy)
		begin
			ready <= req_valid && !ready;
			if (req_valid && ready)
			begin
				ready <= 1'b0;
				busy <= 1'b1;
				op <= req.op;
				cnt <= lat;
			end
		end
		else if (cnt != 4'h0)
			cnt <= cnt - 4'h1;
		else
		begin
			busy <= 1'b0;
			resp_valid <= 1'b1;
			resp.answered <= ans || cfg;
			resp.collision <= coll && !cfg;
			resp.length <= poll ? poll_len : 8'h04;
			resp.code <= sel ? sel_code : (poll ? poll_cmd : 8'h00);
			rbyte <= sel ? sel_code : 8'h5a;
			rbyte_valid <= ans && !cfg;
		end
	end
endmodule
`default_nettype wire

// ---- sim/tb.sv ----
// Self-checking bench for the passive target lister
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam int PC = 50;
	logic clk = 1'b0, rst = 1'b1, start = 1'b0, abort = 1'b0, uid = 1'b0, halted = 1'b0, mpres = 1'b0;
	logic [7:0] max_n = 8'h01, rate = 8'h00, method = 8'h00, slots = 8'h00, retry = 8'h02;
	logic ans = 1'b0, coll = 1'b0;
	logic [7:0] sel_code = 8'h00, poll_cmd = 8'h01, poll_len = 8'h12;
	logic [3:0] lat = 4'h2;
	logic rv, rr, pv, bv, field, flush, repv, done, flushed;
	pltl_pkg::pltl_rf_req_t req;
	pltl_pkg::pltl_rf_resp_t resp;
	logic [7:0] rbyte, rep_byte, found;
	logic [3:0] ops[$], exp[$];
	logic [7:0] args[$], reps[$];
	logic [23:0] tos[$];
	int n_mismatch = 0, cmp_count = 0;

	always #25 clk = ~clk;

	pltl_lister #(.MAX_TARGETS(2), .PROBE_CYCLES(PC)) i_dut (.CLK(clk), .SYS_RST(rst), .CMD_START(start),
		.CMD_ABORT(abort), .MAX_TARGET_COUNT(max_n), .RATE_MODULATION_SELECT(rate), .UID_PRESENT(uid),
		.START_HALTED(halted), .METHOD_PRESENT(mpres), .POLL_METHOD(method), .TIME_SLOT_COUNT(slots),
		.ACTIVATION_RETRY_LIMIT(retry), .RF_REQ_VALID(rv), .RF_REQ(req), .RF_REQ_READY(rr),
		.RF_RESP_VALID(pv), .RF_RESP(resp), .RF_RESP_BYTE(rbyte), .RF_RESP_BYTE_VALID(bv),
		.RF_FIELD_ON(field), .FLUSH_TARGETS(flush), .REPORT_VALID(repv), .REPORT_BYTE(rep_byte),
		.DONE(done), .FOUND_TARGET_COUNT(found));

	pltl_rf_model i_rf (.clk(clk), .rst(rst), .req_valid(rv), .req(req), .ans(ans), .coll(coll),
		.sel_code(sel_code), .poll_cmd(poll_cmd), .poll_len(poll_len), .lat(lat), .ready(rr),
		.resp_valid(pv), .resp(resp), .rbyte(rbyte), .rbyte_valid(bv));

	// ----------------------------------------
	// Monitor
	// ----------------------------------------
	always @(posedge clk)
	begin
		if (rv && rr)
		begin
			ops.push_back(req.op);
			args.push_back(req.arg);
			tos.push_back(req.timeout);
		end
		if (repv)
			reps.push_back(rep_byte);
		if (flush)
			flushed = 1'b1;
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic complete_run();
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] want, input string what);
		cmp_count++;
		if (got !== want)
		begin
			n_mismatch++;
			$display("MISMATCH %0t %s got %0h want %0h", $time, what, got, want);
		end
	endtask

	task automatic setup(input logic [7:0] r, input logic [7:0] m, input logic a);
		@(posedge clk);
		rate <= r;
		max_n <= m;
		ans <= a;
	endtask

	task automatic go();
		ops.delete();
		args.delete();
		tos.delete();
		reps.delete();
		flushed = 1'b0;
		@(posedge clk) start <= 1'b1;
		@(posedge clk) start <= 1'b0;
	endtask

	// Bounded wait, so a stuck sequencer shows as a mismatch
	task automatic run(input logic [7:0] n);
		int i = 0;
		go();
		while (done !== 1'b1 && i < 4000)
		begin
			@(posedge clk);
			i++;
		end
		check(done, 1'b1, "done");
		check(found, n, "count");
		check(flushed, 1'b1, "flush");
		for (int k = 0; k < 4; k++)
			check(args[k], 8'h0a + k, "cfg item");
		if (exp.size() > 0)
		begin
			check(ops.size(), exp.size() + 4, "frame count");
			foreach (exp[k])
				check(ops[k + 4], exp[k], "frame");
		end
		exp.delete();
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_none();
		setup(8'h00, 8'h01, 1'b0);
		run(8'h00);
		check(ops[4], 4'h0, "sense probe");
		check(tos[4], 24'(PC), "probe timeout");
		check(ops.size(), 7, "retries");
	endtask

	task automatic t_type_a();
		setup(8'h00, 8'h02, 1'b1);
		uid <= 1'b1;
		sel_code <= 8'h20;
		exp = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h1, 4'h2, 4'h3, 4'h4};
		run(8'h02);
		setup(8'h00, 8'h02, 1'b1);
		uid <= 1'b0;
		sel_code <= 8'h08;
		coll <= 1'b1;
		exp = '{4'h0, 4'h2, 4'h3, 4'h5, 4'h0, 4'h2, 4'h3};
		run(8'h02);
		check(reps[0], 8'h00, "sense collision");
	endtask

	task automatic t_type_b();
		setup(8'h03, 8'h02, 1'b1);
		halted <= 1'b1;
		mpres <= 1'b1;
		method <= 8'h01;
		lat <= 4'h9;
		exp = '{4'h8, 4'h7, 4'ha, 4'h6, 4'h8, 4'h7, 4'ha};
		run(8'h02);
		setup(8'h03, 8'h01, 1'b1);
		halted <= 1'b0;
		mpres <= 1'b0;
		lat <= 4'h2;
		exp = '{4'h7, 4'h9, 4'ha};
		run(8'h01);
		setup(8'h03, 8'h01, 1'b1);
		mpres <= 1'b1;
		method <= 8'h02;
		exp = '{4'h7, 4'h9, 4'ha};
		run(8'h01);
	endtask

	task automatic t_poll();
		setup(8'h01, 8'h01, 1'b1);
		slots <= 8'h03;
		exp = '{4'hb};
		run(8'h01);
		check(tos[4], 24'(pltl_pkg::POLL_TD_CYC + 4 * pltl_pkg::POLL_TS_CYC), "poll timeout");
		check(reps[0], 8'h01, "first number");
		setup(8'h02, 8'h01, 1'b1);
		slots <= 8'h00;
		poll_len <= 8'h14;
		run(8'h01);
		check(tos[4], 24'(pltl_pkg::POLL_TD_CYC + pltl_pkg::POLL_TS_CYC), "poll timeout");
		setup(8'h01, 8'h01, 1'b1);
		poll_cmd <= 8'h02;
		run(8'h00);
		setup(8'h01, 8'h01, 1'b1);
		poll_cmd <= 8'h01;
		poll_len <= 8'h13;
		run(8'h00);
	endtask

	task automatic t_tag();
		setup(8'h04, 8'h02, 1'b1);
		exp = '{4'hc, 4'hd};
		run(8'h01);
		check(reps[1], 8'h01, "tag number");
	endtask

	task automatic t_abort();
		setup(8'h00, 8'h01, 1'b0);
		retry <= 8'hff;
		go();
		repeat (30) @(posedge clk);
		check(field, 1'b1, "field on");
		abort <= 1'b1;
		@(posedge clk) abort <= 1'b0;
		repeat (3) @(posedge clk);
		check(field, 1'b0, "field after abort");
	endtask

	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial
	begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		t_none();
		t_type_a();
		t_type_b();
		t_poll();
		t_tag();
		t_abort();
		complete_run();
	end

	initial
	begin
		repeat (30000) @(posedge clk);
		n_mismatch++;
		complete_run();
	end
endmodule
`default_nettype wire
